//--- src/fmsp_pkg.sv
package fmsp_pkg;

   // register offsets
   localparam logic [7:0]  ADDR_BUF      = 8'h07;
   localparam logic [7:0]  ADDR_BAUD     = 8'h0e;
   localparam logic [7:0]  ADDR_CTRL     = 8'h11;

   // control field positions (bits 7:5 of a control write are ignored)
   localparam int          CTRL_PEN      = 2;
   localparam int          CTRL_REN      = 3;
   localparam int          CTRL_TB8      = 4;
   localparam int          CTRL_W        = 5;

   // status field positions (bits 4:0 read as zero)
   localparam int          STAT_TI       = 5;
   localparam int          STAT_RI       = 6;
   localparam int          STAT_RB8      = 7;

   // reset values
   localparam logic [4:0]  CTRL_RST      = 5'h00;
   localparam logic [15:0] BAUD_RST      = 16'h0000;
   localparam logic [7:0]  BYTE_RST      = 8'h00;

   // baud divisor layout
   localparam int          BAUD_SRC_BIT  = 15;
   localparam int          DIV_W         = 15;

   // timing counts, in baud ticks and bit indices
   localparam logic [5:0]  M0_LAST_PH    = 6'h03;
   localparam logic [5:0]  M0_MID_PH     = 6'h01;
   localparam logic [5:0]  ASYNC_LAST_PH = 6'h3f;
   localparam logic [5:0]  ASYNC_MID_PH  = 6'h1f;
   localparam logic [3:0]  M0_LAST_BIT   = 4'h7;
   localparam logic [3:0]  DATA_LAST_8   = 4'h8;
   localparam logic [3:0]  DATA_LAST_9   = 4'h9;
   localparam logic [3:0]  STOP_IDX_8    = 4'h9;
   localparam logic [3:0]  STOP_IDX_9    = 4'ha;

   typedef enum logic [1:0] {MODE_SYNC, MODE_ASYNC8, MODE_ADDR9, MODE_NINE} fmsp_mode_t;
   typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} fmsp_tx_state_t;
   typedef enum logic       {RX_IDLE, RX_BUSY} fmsp_rx_state_t;

endpackage

//--- src/fmsp_baud_if.sv
`timescale 1ns/1ns
interface fmsp_baud_if;
   logic [14:0] divisor;
   logic        run;
   logic        tick;

   modport gen  (input divisor, input run, output tick);
   modport user (output divisor, output run, input tick);
endinterface

//--- src/fmsp_baud_gen.sv
`timescale 1ns/1ns
module fmsp_baud_gen (
   // clock and reset
   input  wire logic   ref_clk_i,
   input  wire logic   srst_i,
   // divisor and tick
   fmsp_baud_if.gen    bif
);

   logic [14:0] cnt_q;
   logic        tick_q;
   logic        expire_w;

   assign expire_w = (cnt_q == bif.divisor);
   assign bif.tick = tick_q;

   // one tick every divisor+1 cycles, counter reloads on expiry
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !bif.run) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= expire_w ? '0 : cnt_q + 15'h0001;
         tick_q <= expire_w;
      end
   end

endmodule // fmsp_baud_gen

//--- src/fmsp_pin_sync.sv
`timescale 1ns/1ns
module fmsp_pin_sync (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   // pin side
   input  wire logic pin_i,
   // clean side
   output logic      level_o,
   output logic      fall_o
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic fall_q;

   // a change counts only once the second and third stages agree
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s1_q    <= 1'b1;
         s2_q    <= 1'b1;
         s3_q    <= 1'b1;
         level_q <= 1'b1;
         fall_q  <= 1'b0;
      end else begin
         s1_q    <= pin_i;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         level_q <= (s2_q == s3_q) ? s3_q : level_q;
         fall_q  <= (s2_q == s3_q) && level_q && !s3_q;
      end
   end

   assign level_o = level_q;
   assign fall_o  = fall_q;

endmodule // fmsp_pin_sync

//--- src/fmsp_serial_port.sv
`timescale 1ns/1ns
module fmsp_serial_port (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   // register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic [7:0]      reg_rdata_o,
   // serial pins
   input  wire logic       rx_line_i,
   output logic            rx_line_o,
   output logic            rx_line_oe_o,
   output logic            tx_line_o,
   // interrupt request
   output logic            irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [4:0]                 ctrl_q;
   logic [4:0]                 ctrl_d;
   logic [15:0]                baud_q;
   logic [7:0]                 baud_lo_q;
   logic                       baud_half_q;
   logic [7:0]                 rx_buf_q;
   logic [7:0]                 rx_buf_d;
   logic                       rx8_q;
   logic                       rx8_d;
   logic                       ri_q;
   logic                       ri_d;
   logic                       ti_q;
   logic                       ti_d;
   logic [7:0]                 tx_hold_q;
   logic                       tx_pend_q;
   logic                       tx_pend_d;
   logic [7:0]                 rdata_q;
   logic [7:0]                 rdata_d;
   logic                       irq_q;
   logic                       tx_line_q;
   logic                       rx_out_q;
   logic                       rx_oe_q;

   fmsp_pkg::fmsp_tx_state_t   tx_state_q;
   logic [5:0]                 tx_ph_q;
   logic [3:0]                 tx_cnt_q;
   logic [10:0]                tx_sh_q;
   logic                       m0_rx_q;

   fmsp_pkg::fmsp_rx_state_t   rx_state_q;
   logic [5:0]                 rx_ph_q;
   logic [3:0]                 rx_cnt_q;
   logic [8:0]                 rx_sh_q;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   fmsp_pkg::fmsp_mode_t       mode_w;
   logic                       buf_wr_w;
   logic                       buf_rd_w;
   logic                       baud_wr_w;
   logic                       ctrl_wr_w;
   logic                       stat_rd_w;
   logic                       mode_chg_w;
   logic                       port_rst_w;
   logic                       async_w;
   logic                       nine_w;
   logic                       pen_w;
   logic                       ren_w;
   logic                       ren_rise_w;

   assign mode_w     = fmsp_pkg::fmsp_mode_t'(ctrl_q[1:0]);
   assign buf_wr_w   = reg_wr_i && (reg_addr_i == fmsp_pkg::ADDR_BUF);
   assign buf_rd_w   = reg_rd_i && (reg_addr_i == fmsp_pkg::ADDR_BUF);
   assign baud_wr_w  = reg_wr_i && (reg_addr_i == fmsp_pkg::ADDR_BAUD);
   assign ctrl_wr_w  = reg_wr_i && (reg_addr_i == fmsp_pkg::ADDR_CTRL);
   assign stat_rd_w  = reg_rd_i && (reg_addr_i == fmsp_pkg::ADDR_CTRL);
   assign mode_chg_w = ctrl_wr_w && (reg_wdata_i[1:0] != ctrl_q[1:0]);
   assign port_rst_w = srst_i || mode_chg_w;
   assign async_w    = (mode_w != fmsp_pkg::MODE_SYNC);
   assign nine_w     = ctrl_q[1];
   assign pen_w      = ctrl_q[fmsp_pkg::CTRL_PEN];
   assign ren_w      = ctrl_q[fmsp_pkg::CTRL_REN];
   assign ren_rise_w = ctrl_wr_w && reg_wdata_i[fmsp_pkg::CTRL_REN] && !ren_w;

   ////////////////////////////////////////////////////////////////////////////
   // baud generator and receive pin

   fmsp_baud_if bif ();
   logic        tick_w;
   logic        rx_lvl_w;
   logic        rx_fall_w;

   // halted while the divisor is half written or the source is off
   assign bif.divisor = baud_q[fmsp_pkg::DIV_W-1:0];
   assign bif.run     = baud_q[fmsp_pkg::BAUD_SRC_BIT] && !baud_half_q;
   assign tick_w      = bif.tick;

   fmsp_baud_gen u_baud (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .bif       (bif)
   );

   fmsp_pin_sync u_rx_sync (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .pin_i     (rx_line_i),
      .level_o   (rx_lvl_w),
      .fall_o    (rx_fall_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // transmit frame assembly

   logic        par7_w;
   logic        par8_w;
   logic        bit7_w;
   logic        ninth_w;
   logic [10:0] frame_w;
   logic [3:0]  data_last_w;
   logic [3:0]  stop_idx_w;
   logic        tx_go_w;
   logic        tx_acc_w;
   logic        m0_rx_go_w;

   assign par7_w  = ^tx_hold_q[6:0];
   assign par8_w  = ^tx_hold_q;
   assign bit7_w  = (mode_w == fmsp_pkg::MODE_ASYNC8 && pen_w) ? par7_w : tx_hold_q[7];
   // mode 2 ignores the parity enable entirely
   assign ninth_w = (mode_w == fmsp_pkg::MODE_NINE && pen_w) ? par8_w
                                                             : ctrl_q[fmsp_pkg::CTRL_TB8];
   assign frame_w = nine_w ? {1'b1, ninth_w, bit7_w, tx_hold_q[6:0], 1'b0}
                           : {2'b11, bit7_w, tx_hold_q[6:0], 1'b0};
   assign data_last_w = nine_w ? fmsp_pkg::DATA_LAST_9 : fmsp_pkg::DATA_LAST_8;
   assign stop_idx_w  = nine_w ? fmsp_pkg::STOP_IDX_9 : fmsp_pkg::STOP_IDX_8;

   // mode 0 writes only count with the receive enable set
   assign tx_acc_w   = buf_wr_w && (async_w || ren_w);
   // held data waits for the stop bit of the frame on the line
   assign tx_go_w    = (tx_state_q == fmsp_pkg::TX_IDLE) && tx_pend_q;
   assign tx_pend_d  = tx_acc_w || (tx_pend_q && !tx_go_w);
   assign m0_rx_go_w = !async_w && (tx_state_q == fmsp_pkg::TX_IDLE) && !tx_pend_q &&
                       (ren_rise_w || (stat_rd_w && ri_q && ren_w));

   ////////////////////////////////////////////////////////////////////////////
   // transmit and mode 0 engine

   always_ff @(posedge ref_clk_i) begin
      if (port_rst_w) begin
         tx_state_q <= fmsp_pkg::TX_IDLE;
         tx_ph_q    <= '0;
         tx_cnt_q   <= '0;
         tx_sh_q    <= '1;
         m0_rx_q    <= 1'b0;
      end else begin
         case (tx_state_q)
            fmsp_pkg::TX_IDLE: begin
               tx_ph_q  <= '0;
               tx_cnt_q <= '0;
               if (tx_go_w) begin
                  tx_sh_q    <= async_w ? frame_w : {3'b111, tx_hold_q};
                  m0_rx_q    <= 1'b0;
                  tx_state_q <= async_w ? fmsp_pkg::TX_ASYNC : fmsp_pkg::TX_SYNC;
               end else if (m0_rx_go_w) begin
                  m0_rx_q    <= 1'b1;
                  tx_state_q <= fmsp_pkg::TX_SYNC;
               end
            end
            fmsp_pkg::TX_ASYNC: begin
               if (tick_w) begin
                  tx_ph_q <= tx_ph_q + 6'h01;
                  if (tx_ph_q == fmsp_pkg::ASYNC_LAST_PH) begin
                     tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                     tx_cnt_q <= tx_cnt_q + 4'h1;
                     if (tx_cnt_q == stop_idx_w) begin
                        tx_state_q <= fmsp_pkg::TX_IDLE;
                     end
                  end
               end
            end
            fmsp_pkg::TX_SYNC: begin
               if (m0_rx_q && !ren_w) begin
                  tx_state_q <= fmsp_pkg::TX_IDLE;
               end else if (tick_w) begin
                  if (tx_ph_q == fmsp_pkg::M0_LAST_PH) begin
                     tx_ph_q  <= '0;
                     tx_sh_q  <= m0_rx_q ? {3'b111, rx_lvl_w, tx_sh_q[7:1]}
                                         : {1'b1, tx_sh_q[10:1]};
                     tx_cnt_q <= tx_cnt_q + 4'h1;
                     if (tx_cnt_q == fmsp_pkg::M0_LAST_BIT) begin
                        tx_state_q <= fmsp_pkg::TX_IDLE;
                     end
                  end else begin
                     tx_ph_q <= tx_ph_q + 6'h01;
                  end
               end
            end
            default: begin
               tx_state_q <= fmsp_pkg::TX_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // asynchronous receive engine, runs beside the transmitter

   logic       rx_sample_w;
   logic       rx_last_w;
   logic [8:0] rx_word_w;
   logic [7:0] rx_byte_w;
   logic       rx_acc_w;
   logic       m0_rx_done_w;
   logic       ti_set_w;

   assign rx_sample_w = (rx_state_q == fmsp_pkg::RX_BUSY) && tick_w &&
                        (rx_ph_q == fmsp_pkg::ASYNC_MID_PH);
   assign rx_last_w   = rx_sample_w && (rx_cnt_q == data_last_w);
   assign rx_word_w   = {rx_lvl_w, rx_sh_q[8:1]};
   assign rx_byte_w   = nine_w ? rx_word_w[7:0] : rx_word_w[8:1];
   assign rx_acc_w    = rx_last_w &&
                        !(mode_w == fmsp_pkg::MODE_ADDR9 && !rx_word_w[8]);

   always_ff @(posedge ref_clk_i) begin
      if (port_rst_w) begin
         rx_state_q <= fmsp_pkg::RX_IDLE;
         rx_ph_q    <= '0;
         rx_cnt_q   <= '0;
         rx_sh_q    <= '0;
      end else begin
         case (rx_state_q)
            fmsp_pkg::RX_IDLE: begin
               rx_ph_q  <= '0;
               rx_cnt_q <= '0;
               if (async_w && ren_w && rx_fall_w) begin
                  rx_state_q <= fmsp_pkg::RX_BUSY;
               end
            end
            fmsp_pkg::RX_BUSY: begin
               if (tick_w) begin
                  rx_ph_q <= rx_ph_q + 6'h01;
               end
               // a start bit high at mid-bit was a glitch
               if (rx_sample_w && rx_cnt_q == 4'h0 && rx_lvl_w) begin
                  rx_state_q <= fmsp_pkg::RX_IDLE;
               end else if (rx_sample_w) begin
                  rx_sh_q  <= rx_word_w;
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_last_w) begin
                     rx_state_q <= fmsp_pkg::RX_IDLE;
                  end
               end
            end
            default: begin
               rx_state_q <= fmsp_pkg::RX_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags, receive buffer, control

   assign m0_rx_done_w = (tx_state_q == fmsp_pkg::TX_SYNC) && m0_rx_q && ren_w && tick_w &&
                         (tx_ph_q == fmsp_pkg::M0_LAST_PH) &&
                         (tx_cnt_q == fmsp_pkg::M0_LAST_BIT);
   assign ti_set_w = tick_w && (
                     ((tx_state_q == fmsp_pkg::TX_ASYNC) && (tx_cnt_q == data_last_w) &&
                      (tx_ph_q == fmsp_pkg::ASYNC_MID_PH)) ||
                     ((tx_state_q == fmsp_pkg::TX_SYNC) && !m0_rx_q &&
                      (tx_cnt_q == fmsp_pkg::M0_LAST_BIT) &&
                      (tx_ph_q == fmsp_pkg::M0_MID_PH)));

   // a set in the clearing cycle wins; only the receive flag gates traffic, restarting mode 0 receive on a status read
   assign ri_d = rx_acc_w || m0_rx_done_w || (ri_q && !stat_rd_w);
   assign ti_d = ti_set_w || (ti_q && !stat_rd_w);

   // completed word parks here while the next one shifts in
   assign rx_buf_d = m0_rx_done_w ? {rx_lvl_w, tx_sh_q[7:1]} :
                     rx_acc_w     ? rx_byte_w : rx_buf_q;
   assign rx8_d    = !rx_acc_w                           ? rx8_q         :
                     (mode_w == fmsp_pkg::MODE_ASYNC8)   ? (pen_w ? ^rx_word_w[8:1] : rx8_q) :
                     (mode_w == fmsp_pkg::MODE_NINE && pen_w) ? ^rx_word_w :
                     rx_word_w[8];

   // software write wins over the clear-on-send of the ninth bit
   assign ctrl_d = ctrl_wr_w ? reg_wdata_i[fmsp_pkg::CTRL_W-1:0] :
                   (tx_go_w && async_w) ? (ctrl_q & ~(5'h01 << fmsp_pkg::CTRL_TB8)) :
                   ctrl_q;

   // unmapped and write-only addresses read as zero
   assign rdata_d = buf_rd_w  ? rx_buf_q :
                    stat_rd_w ? {rx8_q, ri_q, ti_q, 5'h00} : 8'h00;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ctrl_q      <= fmsp_pkg::CTRL_RST;
         baud_q      <= fmsp_pkg::BAUD_RST;
         baud_lo_q   <= fmsp_pkg::BYTE_RST;
         baud_half_q <= 1'b0;
         rx_buf_q    <= fmsp_pkg::BYTE_RST;
         rx8_q       <= 1'b0;
         ri_q        <= 1'b0;
         ti_q        <= 1'b0;
         tx_hold_q   <= fmsp_pkg::BYTE_RST;
         rdata_q     <= fmsp_pkg::BYTE_RST;
      end else begin
         ctrl_q   <= ctrl_d;
         rx_buf_q <= rx_buf_d;
         rx8_q    <= rx8_d;
         ri_q     <= ri_d;
         ti_q     <= ti_d;
         rdata_q  <= rdata_d;
         if (buf_wr_w) begin
            tx_hold_q <= reg_wdata_i;
         end
         if (baud_wr_w) begin
            baud_half_q <= !baud_half_q;
            if (baud_half_q) begin
               baud_q <= {reg_wdata_i, baud_lo_q};
            end else begin
               baud_lo_q <= reg_wdata_i;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin and interrupt outputs, all registered

   logic tx_line_d;

   // mode 0 clock: low for two ticks, high for two, data held across
   assign tx_line_d = (tx_state_q == fmsp_pkg::TX_ASYNC) ? tx_sh_q[0] :
                      (tx_state_q == fmsp_pkg::TX_SYNC)  ? tx_ph_q[1] : 1'b1;

   always_ff @(posedge ref_clk_i) begin
      if (port_rst_w) begin
         tx_pend_q <= 1'b0;
         tx_line_q <= 1'b1;
         rx_out_q  <= 1'b1;
         rx_oe_q   <= 1'b0;
      end else begin
         tx_pend_q <= tx_pend_d;
         tx_line_q <= tx_line_d;
         rx_out_q  <= tx_sh_q[0];
         rx_oe_q   <= (tx_state_q == fmsp_pkg::TX_SYNC) && !m0_rx_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= ri_d || ti_d;
      end
   end

   assign reg_rdata_o  = rdata_q;
   assign tx_line_o    = tx_line_q;
   assign rx_line_o    = rx_out_q;
   assign rx_line_oe_o = rx_oe_q;
   assign irq_o        = irq_q;

endmodule // fmsp_serial_port

//--- testbench/fmsp_chk.sv
`timescale 1ns/1ns
module fmsp_chk (
   // clock and reset
   input wire logic       ref_clk_i,
   input wire logic       srst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // serial pins and request
   input wire logic       rx_line_i,
   input wire logic       rx_line_o,
   input wire logic       rx_line_oe_o,
   input wire logic       tx_line_o,
   input wire logic       irq_o
);
   logic [3:0]  fall_cnt_q;
   logic [10:0] low_run_q;
   logic [3:0]  wr_hist_q;
   logic        tx_q;
   logic        oe_q;
   wire         tx_fall = tx_q & ~tx_line_o;
   wire         rd_stat = reg_rd_i & (reg_addr_i == fmsp_pkg::ADDR_CTRL);
   // writes may cut a clock phase short, so runs right after one are exempt
   always_ff @(posedge ref_clk_i) begin
      tx_q <= tx_line_o;
      oe_q <= rx_line_oe_o;
      wr_hist_q <= {wr_hist_q[2:0], reg_wr_i};
      low_run_q <= tx_line_o ? 11'h000 : low_run_q + 11'h001;
      if (rx_line_oe_o & ~oe_q) fall_cnt_q <= {3'h0, tx_fall};
      else if (rx_line_oe_o & tx_fall) fall_cnt_q <= fall_cnt_q + 4'h1;
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_stat_rd; rd_stat; endsequence
   sequence s_m0_hold; rx_line_oe_o [*8]; endsequence
   property p_rst; $fell(srst_i) |-> tx_line_o && !irq_o && !rx_line_oe_o; endproperty
   property p_quiet; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
   property p_low; s_stat_rd |=> reg_rdata_o[4:0] == 5'h00; endproperty
   property p_irq_or; s_stat_rd |=> (|reg_rdata_o[6:5]) == $past(irq_o); endproperty
   property p_hold; $fell(irq_o) |-> $past(rd_stat); endproperty
   property p_m0_oe; $rose(rx_line_oe_o) |-> s_m0_hold; endproperty
   property p_m0_clk; $fell(rx_line_oe_o) |-> fall_cnt_q == 4'h8; endproperty
   property p_bit;
      $rose(tx_line_o) && wr_hist_q == 4'h0 |-> low_run_q inside {11'h003, 11'h004}
         || low_run_q[6:0] inside {7'h00, 7'h01, 7'h7f};
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not idle after reset");
   a_quiet: assert property (p_quiet)
      else $error("read data outside read slot");
   a_low: assert property (p_low)
      else $error("status low bits not zero");
   a_irq_or: assert property (p_irq_or)
      else $error("irq differs from done flags");
   a_hold: assert property (p_hold)
      else $error("irq dropped without status read");
   a_m0_oe: assert property (p_m0_oe)
      else $error("shift drive too short");
   a_m0_clk: assert property (p_m0_clk)
      else $error("shift clock count wrong");
   a_bit: assert property (p_bit)
      else $error("low time not whole bit periods");
endmodule // fmsp_chk

bind fmsp_serial_port fmsp_chk u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_line_i(rx_line_i),
   .rx_line_o(rx_line_o), .rx_line_oe_o(rx_line_oe_o), .tx_line_o(tx_line_o),
   .irq_o(irq_o));

//--- testbench/fmsp_remote.sv
`timescale 1ns/1ns
module fmsp_remote (
   // clock
   input  wire logic clk_i,
   // device pins
   input  wire logic tx_line_i,
   input  wire logic dat_i,
   input  wire logic oe_i,
   // line toward the device
   output logic      line_o
);
   localparam int BT = 128; // clocks per async bit at divisor 1
   logic [7:0] m0_out = 8'h00;
   logic [7:0] m0_got = 8'h00;
   logic       m0_on = 1'b0;
   initial line_o = 1'b1;
   ////////////////////////////////////////////////////////////
   // shift out on clock fall, in on rise, lsb first; refills inverted
   always @(negedge tx_line_i) begin
      if (m0_on && !oe_i) begin
         line_o <= m0_out[0];
         m0_out <= {~m0_out[0], m0_out[7:1]};
      end
   end
   always @(posedge tx_line_i) begin
      if (oe_i) m0_got <= {dat_i, m0_got[7:1]};
   end
   task automatic m0_load(input logic [7:0] d);
      m0_out = d;
      m0_on = 1'b1;
   endtask
   task automatic m0_off;
      m0_on = 1'b0;
      line_o <= 1'b1;
   endtask
   // start low, data lsb first, stop high
   task automatic send(input logic [9:0] v, input int n);
      for (int i = -1; i <= n; i++) begin
         @(posedge clk_i);
         line_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : v[i];
         repeat (BT - 1) @(posedge clk_i);
      end
   endtask
   // samples mid-bit; bit n of the result is the stop bit
   task automatic get(output logic [9:0] v, input int n);
      v = 10'h000;
      @(negedge tx_line_i);
      repeat (BT / 2) @(posedge clk_i);
      for (int i = 0; i <= n; i++) begin
         repeat (BT) @(posedge clk_i);
         v[i] = tx_line_i;
      end
   endtask
endmodule // fmsp_remote

//--- testbench/fmsp_serial_port_tb.sv
`timescale 1ns/1ns
module fmsp_serial_port_tb;
   logic       ref_clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic       reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic       line_w, rx_line_o, rx_line_oe_o, tx_line_o, irq_o;
   logic [9:0] v;
   int         fail_count = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   logic [7:0] tc [5] = '{8'h01, 8'h05, 8'h13, 8'h17, 8'h12};
   logic [7:0] td [5] = '{8'h5a, 8'h07, 8'h11, 8'h01, 8'h81};
   logic [9:0] te [5] = '{10'h15a, 10'h187, 10'h311, 10'h301, 10'h381};
   logic [7:0] rc [7] = '{8'h09, 8'h0d, 8'h0d, 8'h0a, 8'h0a, 8'h0b, 8'h0f};
   logic [9:0] rv [7] = '{10'h05a, 10'h087, 10'h007, 10'h0a5, 10'h1a5, 10'h03c, 10'h13c};
   // ninth rx bit is only rewritten by a stored frame, so a dropped one leaves it set
   logic [7:0] rs [7] = '{8'h40, 8'h40, 8'hc0, 8'h80, 8'hc0, 8'h40, 8'hc0};
   wire        rx_pin = rx_line_oe_o ? rx_line_o : line_w;
   always #50 ref_clk_i = ~ref_clk_i;
   fmsp_serial_port dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .rx_line_i(rx_pin), .rx_line_o(rx_line_o),
      .rx_line_oe_o(rx_line_oe_o), .tx_line_o(tx_line_o), .irq_o(irq_o));
   // tx pin taken as already routed to the port by software
   fmsp_remote u_far (.clk_i(ref_clk_i), .tx_line_i(tx_line_o), .dat_i(rx_pin),
      .oe_i(rx_line_oe_o), .line_o(line_w));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(nm, {2'b00, e}, {2'b00, reg_rdata_o});
   endtask
   task automatic wirq;
      int n;
      n = 0;
      while (irq_o !== 1'b1 && n < 3000) begin
         @(posedge ref_clk_i);
         n++;
      end
      chk("irq wait", 10'h001, {9'h000, irq_o});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // whole run is about 21k cycles
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         end_of_test;
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      wr(fmsp_pkg::ADDR_BAUD, 8'h01);
      wr(fmsp_pkg::ADDR_BAUD, 8'h80);
      rd(fmsp_pkg::ADDR_CTRL, 8'h00, "status");
      rd(8'h20, 8'h00, "unmapped");
      u_far.m0_load(8'h3c);
      wr(fmsp_pkg::ADDR_CTRL, 8'h08);
      wirq;
      wr(fmsp_pkg::ADDR_CTRL, 8'h00);
      rd(fmsp_pkg::ADDR_CTRL, 8'h40, "m0 rx status");
      rd(fmsp_pkg::ADDR_BUF, 8'h3c, "m0 rx data");
      wr(fmsp_pkg::ADDR_BUF, 8'ha5);
      repeat (200) @(posedge ref_clk_i);
      rd(fmsp_pkg::ADDR_CTRL, 8'h00, "m0 no start");
      u_far.m0_load(8'hc3);
      wr(fmsp_pkg::ADDR_CTRL, 8'h08);
      wirq;
      wr(fmsp_pkg::ADDR_BUF, 8'h96);
      // eight bits of four ticks, two clocks a tick, plus margin
      repeat (80) @(posedge ref_clk_i);
      wr(fmsp_pkg::ADDR_CTRL, 8'h00);
      rd(fmsp_pkg::ADDR_CTRL, 8'h60, "m0 flags");
      rd(fmsp_pkg::ADDR_BUF, 8'hc3, "m0 rx data");
      chk("m0 tx data", 10'h096, {2'b00, u_far.m0_got});
      wr(fmsp_pkg::ADDR_CTRL, 8'h08);
      repeat (20) @(posedge ref_clk_i);
      wr(fmsp_pkg::ADDR_CTRL, 8'h00);
      repeat (200) @(posedge ref_clk_i);
      rd(fmsp_pkg::ADDR_CTRL, 8'h00, "m0 abort");
      u_far.m0_off;
      for (int i = 0; i < 5; i++) begin
         wr(fmsp_pkg::ADDR_CTRL, tc[i]);
         fork
            u_far.get(v, i < 2 ? 8 : 9);
            wr(fmsp_pkg::ADDR_BUF, td[i]);
         join
         chk("tx frame", te[i], v);
         rd(fmsp_pkg::ADDR_CTRL, 8'h20, "tx done");
      end
      fork
         u_far.get(v, 9);
         wr(fmsp_pkg::ADDR_BUF, 8'h81);
      join
      chk("ninth cleared", 10'h281, v);
      rd(fmsp_pkg::ADDR_CTRL, 8'h20, "tx done");
      for (int i = 0; i < 7; i++) begin
         wr(fmsp_pkg::ADDR_CTRL, rc[i]);
         u_far.send(rv[i], rc[i][1] ? 9 : 8);
         rd(fmsp_pkg::ADDR_CTRL, rs[i], "rx status");
         if (!rc[i][2] && rs[i][6]) rd(fmsp_pkg::ADDR_BUF, rv[i][7:0], "rx data");
      end
      wr(fmsp_pkg::ADDR_CTRL, 8'h09);
      fork
         u_far.send(10'h0c3, 8);
         u_far.get(v, 8);
         wr(fmsp_pkg::ADDR_BUF, 8'h3c);
      join
      chk("duplex tx", 10'h13c, v);
      // mode 1 without parity leaves the ninth rx bit from the last mode 3 frame
      rd(fmsp_pkg::ADDR_CTRL, 8'he0, "duplex flags");
      rd(fmsp_pkg::ADDR_BUF, 8'hc3, "duplex rx");
      wr(fmsp_pkg::ADDR_CTRL, 8'h01);
      wr(fmsp_pkg::ADDR_BUF, 8'hff);
      repeat (300) @(posedge ref_clk_i);
      wr(fmsp_pkg::ADDR_CTRL, 8'h03);
      repeat (1500) @(posedge ref_clk_i);
      rd(fmsp_pkg::ADDR_CTRL, 8'h80, "mode abort");
      end_of_test;
   end
endmodule // fmsp_serial_port_tb
